// ### logic/cmc_top.sv
// Clock multiplier control register, fine trim and pulse multiplier
//
// Overview of operation
// - Fine trim bits 7:6 read zero; writes to them are ignored.
// - Fine trim bits 5:0 read/write and drive the oscillator trim output.
// - Fine trim loads the factory value after reset, not a constant.
// - Output is four times input scaled by 1,2/3,1/2,2/5,1/3 or 2/7.
// - Input is external, internal halved, or external halved.
// - Base outputs are internal x2, external x2, external x4.
// - Each input rising edge yields a burst of four fast pulses.
// - Control register at 0x97 page 0x0f, fields as mapped, reset zero.
// - Fine trim register decoded at 0x9e on the same page.
// - Multiplier runs only while the enable bit is one.
// - Writing init while enabled starts initialisation; reads zero before.
// - Ready reads one only after the initialised multiplier stabilises.
`include "cmc_defs.svh"
`default_nettype none
module cmc_top #(
  parameter int unsigned LOCK_CYC = `CMC_LOCK_CYC
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire cmc_pkg::cmc_byte_t SFR_PAGE_I,
  input wire cmc_pkg::cmc_byte_t SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire cmc_pkg::cmc_byte_t SFR_WDATA_I,
  input wire cmc_pkg::cmc_trim_t FACTORY_TRIM_I,
  input wire logic INT_OSC_I,
  input wire logic EXT_OSC_I,
  output var cmc_pkg::cmc_byte_t SFR_RDATA_O,
  output var cmc_pkg::cmc_trim_t TRIM_O,
  output logic MUL_EN_O,
  output logic MUL_RDY_O,
  output logic MUL_PULSE_O
);
  import cmc_pkg::*;

  localparam logic [`CMC_CNT_W-1:0] LOCK_LAST =
    `CMC_CNT_W'(LOCK_CYC - 1);

  // Decodes an SFR access to one register on the clock page
  function automatic logic sfr_hit(input cmc_byte_t page,
                                   input cmc_byte_t addr,
                                   input cmc_byte_t want);
    return (page == `CMC_PAGE) && (addr == want);
  endfunction

  // Scaling code to denominator of 2/N; spare codes fall back to 1
  function automatic logic [3:0] scale_den(input logic [2:0] code);
    logic [3:0] den;
    den = 4'h2;
    case (code)
      3'h0: den = 4'h2;
      3'h1: den = 4'h3;
      3'h2: den = 4'h4;
      3'h3: den = 4'h5;
      3'h4: den = 4'h6;
      3'h5: den = 4'h7;
      default: den = 4'h2;
    endcase
    return den;
  endfunction

  logic sel_ctrl;
  logic sel_trim;
  logic wr_ctrl;
  logic wr_trim;
  logic init_start;
  logic en_ff;
  logic init_ff;
  logic [2:0] scale_ff;
  cmc_src_e src_ff;
  cmc_lock_e st_ff;
  cmc_lock_e nxt_st;
  logic [`CMC_CNT_W-1:0] cnt_ff;
  logic rdy;
  logic loaded_ff;
  cmc_trim_t trim_ff;
  cmc_byte_t rdata_ff;
  logic int_q_ff;
  logic ext_q_ff;
  logic int_half_ff;
  logic ext_half_ff;
  logic src_lvl;
  logic src_q_ff;
  logic src_rise;
  logic [3:0] burst_ff;
  logic [3:0] nxt_burst;
  logic fast;
  logic [3:0] acc_ff;
  logic [3:0] acc_sum;
  logic [3:0] den;
  logic fire;
  logic pulse_ff;

  // Register decode on the SFR port
  assign sel_ctrl = sfr_hit(SFR_PAGE_I, SFR_ADDR_I, `CMC_ADDR_CTRL);
  assign sel_trim = sfr_hit(SFR_PAGE_I, SFR_ADDR_I, `CMC_ADDR_TRIM);
  assign wr_ctrl = SFR_WR_I && sel_ctrl;
  assign wr_trim = SFR_WR_I && sel_trim;
  // Init only counts when the multiplier was already enabled
  assign init_start = wr_ctrl && SFR_WDATA_I[`CMC_BIT_EN] &&
                      SFR_WDATA_I[`CMC_BIT_INIT] && en_ff;

  // Control fields; a zero write clears everything
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      en_ff <= 1'b0;
      init_ff <= 1'b0;
      scale_ff <= `CMC_SCL_RST;
      src_ff <= CMC_SRC_EXT;
    end else if (wr_ctrl) begin
      en_ff <= SFR_WDATA_I[`CMC_BIT_EN];
      init_ff <= init_start;
      scale_ff <= SFR_WDATA_I[`CMC_SCL_HI:`CMC_SCL_LO];
      src_ff <= cmc_src_e'(SFR_WDATA_I[`CMC_SRC_HI:`CMC_SRC_LO]);
    end
  end

  // Lock sequence; disable or re-init wins over the running state
  always_comb begin
    nxt_st = st_ff;
    if (wr_ctrl && !SFR_WDATA_I[`CMC_BIT_EN]) begin
      nxt_st = CMC_OFF;
    end else if (init_start) begin
      nxt_st = CMC_LOCKING;
    end else begin
      case (st_ff)
        CMC_OFF: begin
          if (en_ff) begin
            nxt_st = CMC_ARMED;
          end
        end
        CMC_ARMED: nxt_st = CMC_ARMED;
        CMC_LOCKING: begin
          if (cnt_ff == LOCK_LAST) begin
            nxt_st = CMC_READY;
          end
        end
        CMC_READY: nxt_st = CMC_READY;
        default: nxt_st = CMC_OFF;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st_ff <= CMC_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Stabilisation timer, restarted by every init write
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cnt_ff <= '0;
    end else if (init_start || st_ff != CMC_LOCKING) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign rdy = (st_ff == CMC_READY);

  // Fine trim; factory value caught one edge after reset release
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      loaded_ff <= 1'b0;
      trim_ff <= `CMC_TRIM_RST;
    end else if (!loaded_ff) begin
      loaded_ff <= 1'b1;
      trim_ff <= FACTORY_TRIM_I;
    end else if (wr_trim) begin
      trim_ff <= SFR_WDATA_I[`CMC_TRIM_HI:0];
    end
  end

  // Read data, registered on the read strobe
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_ff <= `CMC_RD_NONE;
    end else if (SFR_RD_I) begin
      if (sel_ctrl) begin
        rdata_ff <= {en_ff, init_ff, rdy, scale_ff, src_ff};
      end else if (sel_trim) begin
        rdata_ff <= {`CMC_TRIM_UNUSED, trim_ff};
      end else begin
        rdata_ff <= `CMC_RD_NONE;
      end
    end
  end

  // Halving dividers, toggled on each input rising edge
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      int_q_ff <= 1'b0;
      ext_q_ff <= 1'b0;
      int_half_ff <= 1'b0;
      ext_half_ff <= 1'b0;
    end else begin
      int_q_ff <= INT_OSC_I;
      ext_q_ff <= EXT_OSC_I;
      if (INT_OSC_I && !int_q_ff) begin
        int_half_ff <= !int_half_ff;
      end
      if (EXT_OSC_I && !ext_q_ff) begin
        ext_half_ff <= !ext_half_ff;
      end
    end
  end

  // Source choice; spare code also takes external halved
  always_comb begin
    case (src_ff)
      CMC_SRC_EXT: src_lvl = EXT_OSC_I;
      CMC_SRC_INT_HALF: src_lvl = int_half_ff;
      default: src_lvl = ext_half_ff;
    endcase
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      src_q_ff <= 1'b0;
    end else begin
      src_q_ff <= src_lvl;
    end
  end

  assign src_rise = src_lvl && !src_q_ff;

  // Four fast pulses per source edge; later edges queue behind
  always_comb begin
    nxt_burst = burst_ff;
    if (fast) begin
      nxt_burst = burst_ff - 4'h1;
    end
    if (src_rise) begin
      nxt_burst = nxt_burst + `CMC_BURST;
    end
  end

  assign fast = (burst_ff != `CMC_BURST_NONE);

  // Burst store is flushed whenever the multiplier is off
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      burst_ff <= `CMC_BURST_NONE;
    end else if (!en_ff) begin
      burst_ff <= `CMC_BURST_NONE;
    end else begin
      burst_ff <= nxt_burst;
    end
  end

  // Fractional 2/N scaler; keeps average rate exact, jitter one pulse
  assign den = scale_den(scale_ff);
  assign acc_sum = acc_ff + `CMC_SCALE_NUM;
  assign fire = fast && (acc_sum >= den);

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      acc_ff <= 4'h0;
    end else if (!en_ff) begin
      acc_ff <= 4'h0;
    end else if (fast) begin
      acc_ff <= fire ? acc_sum - den : acc_sum;
    end
  end

  // Output pulse only once the multiplier has stabilised
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= en_ff && rdy && fire;
    end
  end

  assign SFR_RDATA_O = rdata_ff;
  assign TRIM_O = trim_ff;
  assign MUL_EN_O = en_ff;
  assign MUL_RDY_O = rdy;
  assign MUL_PULSE_O = pulse_ff;

  // Checks kept beside the logic they guard
  sequence s_four_fast;
    fast [*4];
  endsequence

  a_trim_upper: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    SFR_RD_I && sel_trim |=>
      SFR_RDATA_O[`CMC_BYTE_HI:`CMC_TRIM_HI+1] == `CMC_TRIM_UNUSED)
    else $error("trim upper bits not zero");
  a_trim_write: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    wr_trim && loaded_ff |=>
      TRIM_O == $past(SFR_WDATA_I[`CMC_TRIM_HI:0]))
    else $error("trim write lost");
  a_trim_factory: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    $rose(loaded_ff) |-> TRIM_O == $past(FACTORY_TRIM_I))
    else $error("factory trim not loaded");
  a_burst_four: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    src_rise && en_ff && !fast && !wr_ctrl |=> s_four_fast)
    else $error("burst shorter than four");
  a_unity_fire: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    fast && en_ff && rdy && den == `CMC_SCALE_NUM |=> MUL_PULSE_O)
    else $error("unity scale dropped a pulse");
  a_half_toggle: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    INT_OSC_I && !int_q_ff |=> int_half_ff != $past(int_half_ff))
    else $error("internal halving missed edge");
  a_off_quiet: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !en_ff ##1 !en_ff |->
      !MUL_PULSE_O && burst_ff == `CMC_BURST_NONE)
    else $error("multiplier active while disabled");
  a_init_start: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    init_start |=> st_ff == CMC_LOCKING && !MUL_RDY_O && init_ff)
    else $error("init did not start locking");
  a_ready_late: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    $rose(MUL_RDY_O) |-> $past(cnt_ff) == LOCK_LAST)
    else $error("ready before stabilisation");
  a_ctrl_clear: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    wr_ctrl && SFR_WDATA_I == `CMC_RD_NONE |=>
      !en_ff && !init_ff && !MUL_RDY_O && scale_ff == `CMC_SCL_RST)
    else $error("zero write did not clear control");
  a_ctrl_read: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    SFR_RD_I && sel_ctrl |=>
      SFR_RDATA_O[`CMC_BIT_RDY] == $past(MUL_RDY_O))
    else $error("ready flag read mismatch");
endmodule
`default_nettype wire

// ### logic/cmc_defs.svh
// Register map, field positions and timing constants of the clock multiplier
`ifndef CMC_DEFS_SVH
`define CMC_DEFS_SVH
`define CMC_PAGE 8'h0f
`define CMC_ADDR_CTRL 8'h97
`define CMC_ADDR_TRIM 8'h9e
`define CMC_BIT_EN 7
`define CMC_BIT_INIT 6
`define CMC_BIT_RDY 5
`define CMC_SCL_HI 4
`define CMC_SCL_LO 2
`define CMC_SRC_HI 1
`define CMC_SRC_LO 0
`define CMC_TRIM_HI 5
`define CMC_BYTE_HI 7
`define CMC_TRIM_UNUSED 2'h0
`define CMC_RD_NONE 8'h00
`define CMC_SCL_RST 3'h0
`define CMC_TRIM_RST 6'h00
`define CMC_BURST 4'h4
`define CMC_BURST_NONE 4'h0
`define CMC_SCALE_NUM 4'h2
`define CMC_CNT_W 16
`define CMC_CLK_NS 100
`define CMC_LOCK_NS 20000
`define CMC_LOCK_CYC ((`CMC_LOCK_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)
`endif

// ### logic/cmc_pkg.sv
// Types shared by the clock multiplier design
`default_nettype none
package cmc_pkg;
  typedef logic [7:0] cmc_byte_t;
  typedef logic [5:0] cmc_trim_t;
  // Multiplier input source codes, in field order 0..3
  typedef enum logic [1:0] {
    CMC_SRC_EXT,
    CMC_SRC_INT_HALF,
    CMC_SRC_EXT_HALF,
    CMC_SRC_EXT_HALF_ALT
  } cmc_src_e;
  // Multiplier lock sequence
  typedef enum logic [1:0] {
    CMC_OFF,
    CMC_ARMED,
    CMC_LOCKING,
    CMC_READY
  } cmc_lock_e;
endpackage
`default_nettype wire

// ### tb/clock_multiplier_config_tb.sv
// Self-checking bench for the clock multiplier register block
`include "cmc_defs.svh"
`default_nettype none
module clock_multiplier_config_tb;
  import cmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int LOCK = 4;
  localparam cmc_trim_t FT = 6'h2b;
  localparam cmc_byte_t PG = `CMC_PAGE;
  localparam cmc_byte_t CTRL = `CMC_ADDR_CTRL;
  localparam cmc_byte_t TRIM = `CMC_ADDR_TRIM;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cmc_byte_t page = 8'h00;
  cmc_byte_t addr = 8'h00;
  cmc_byte_t wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic int_osc = 1'b0;
  logic ext_osc = 1'b0;
  cmc_byte_t rdata;
  cmc_trim_t trim;
  logic en;
  logic rdy;
  logic pulse;
  int bad_count = 0;
  int tests_run = 0;
  int pulse_cnt = 0;
  int div [8] = '{2, 3, 4, 5, 6, 7, 2, 2};

  cmc_top #(.LOCK_CYC(LOCK)) DUT (
    .CLK_I(clk), .NRST_I(rst_n), .SFR_PAGE_I(page), .SFR_ADDR_I(addr),
    .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_WDATA_I(wdata),
    .FACTORY_TRIM_I(FT), .INT_OSC_I(int_osc), .EXT_OSC_I(ext_osc),
    .SFR_RDATA_O(rdata), .TRIM_O(trim), .MUL_EN_O(en), .MUL_RDY_O(rdy),
    .MUL_PULSE_O(pulse)
  );

  // Free-running 10 MHz clock
  always #50 clk = ~clk;

  // Pulses counted mid-cycle, away from the edge that launches them
  always @(negedge clk) begin
    if (pulse === 1'b1) pulse_cnt <= pulse_cnt + 1;
  end

  task automatic stop_test;
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] got,
                       input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One write strobe; an idle edge follows so strobes never merge
  task automatic sfr_wr(input cmc_byte_t pg, input cmc_byte_t ad,
                        input cmc_byte_t d);
    page = pg;
    addr = ad;
    wdata = d;
    wr = 1'b1;
    @(posedge clk);
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask

  // Read data is sampled a cycle and a half after the strobe was taken
  task automatic sfr_rd(input cmc_byte_t pg, input cmc_byte_t ad,
                        input cmc_byte_t exp, input string nm);
    page = pg;
    addr = ad;
    rd = 1'b1;
    @(posedge clk);
    @(negedge clk);
    rd = 1'b0;
    @(posedge clk);
    @(negedge clk);
    check(nm, {8'h00, rdata}, {8'h00, exp});
  endtask

  // Slow oscillator: 4 cycles high, 4 low, then time to drain bursts
  task automatic run_count(input logic use_int, input int n,
                           input int exp, input string nm);
    int s;
    s = pulse_cnt;
    repeat (n) begin
      if (use_int) int_osc = 1'b1;
      else ext_osc = 1'b1;
      cycles(4);
      int_osc = 1'b0;
      ext_osc = 1'b0;
      cycles(4);
    end
    cycles(12);
    check(nm, 16'(pulse_cnt - s), 16'(exp));
  endtask

  // Documented bring-up order, then a bounded wait for ready
  task automatic setup(input logic [1:0] src, input logic [2:0] scl);
    cmc_byte_t f;
    int k;
    f = {3'h0, scl, src};
    sfr_wr(PG, CTRL, 8'h00);
    sfr_wr(PG, CTRL, {6'h00, src});
    sfr_wr(PG, CTRL, f);
    sfr_wr(PG, CTRL, f | 8'h80);
    check("enable out", {15'h0, en}, 16'h0001);
    sfr_rd(PG, CTRL, f | 8'h80, "ctrl enabled");
    cycles(50);
    sfr_wr(PG, CTRL, f | 8'hc0);
    check("ready early", {15'h0, rdy}, 16'h0000);
    k = 0;
    while (rdy !== 1'b1 && k < LOCK + 8) begin
      cycles(1);
      k++;
    end
    check("ready", {15'h0, rdy}, 16'h0001);
    sfr_rd(PG, CTRL, f | 8'he0, "ctrl ready");
  endtask

  // Hang guard, well above the expected run of about 13k cycles
  initial begin
    cycles(40000);
    bad_count++;
    stop_test();
  end

  initial begin
    cycles(2);
    rst_n = 1'b1;
    cycles(2);
    sfr_rd(PG, CTRL, 8'h00, "ctrl reset");
    sfr_rd(PG, TRIM, {2'h0, FT}, "trim reset");
    check("trim out", {10'h0, trim}, {10'h0, FT});
    sfr_wr(PG, TRIM, 8'hff);
    sfr_rd(PG, TRIM, 8'h3f, "trim ones");
    check("trim out ones", {10'h0, trim}, 16'h003f);
    sfr_wr(PG, TRIM, 8'h15);
    sfr_rd(PG, TRIM, 8'h15, "trim value");
    sfr_wr(8'h00, TRIM, 8'h2a);
    sfr_rd(PG, TRIM, 8'h15, "trim other page");
    sfr_rd(8'h00, TRIM, 8'h00, "other page read");
    sfr_rd(PG, 8'h98, 8'h00, "unmapped read");
    // Init and ready bits must not stick while enable is low
    sfr_wr(PG, CTRL, 8'h7f);
    sfr_rd(PG, CTRL, 8'h1f, "ctrl fields");
    sfr_wr(PG, CTRL, 8'h00);
    run_count(1'b0, 10, 0, "pulses disabled");
    // 105 direct edges give 420 fast cycles, divisible by every factor
    for (int c = 0; c < 8; c++) begin
      setup(2'h0, 3'(c));
      run_count(1'b0, 105, 840 / div[c], "scaled pulses");
    end
    // Halved sources: 210 edges make 105 halved edges
    for (int s = 1; s < 4; s++) begin
      setup(2'(s), 3'h0);
      run_count(s == 1, 210, 420, "halved source");
    end
    setup(2'h1, 3'h0);
    run_count(1'b0, 10, 0, "unselected osc");
    // Reset in mid-run while ready: all state back to reset values
    rst_n = 1'b0;
    cycles(2);
    check("en in reset", {15'h0, en}, 16'h0000);
    check("rdy in reset", {15'h0, rdy}, 16'h0000);
    rst_n = 1'b1;
    cycles(2);
    sfr_rd(PG, CTRL, 8'h00, "ctrl re-reset");
    sfr_rd(PG, TRIM, {2'h0, FT}, "trim re-reset");
    check("trim out re-reset", {10'h0, trim}, {10'h0, FT});
    sfr_wr(PG, CTRL, 8'h00);
    check("enable off", {15'h0, en}, 16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire
